/* File: hw/rfi_pkg.sv */
// rfi_pkg: register map, field positions, reset values and types for
// the reader irq status block. assumes a 40 MHz clock, APB on 32 bits.
package rfi_pkg;
   // clock and no-response tick
   localparam int RFI_CLK_NS        = 25;
   localparam int RFI_TICK_NS       = 1000;
   localparam int RFI_TICK_CYC      = RFI_TICK_NS / RFI_CLK_NS;
   // register indices and byte addresses
   localparam logic [7:0] RFI_IDX_PROTO  = 8'h01;
   localparam logic [7:0] RFI_IDX_WAIT   = 8'h07;
   localparam logic [7:0] RFI_IDX_STATUS = 8'h0C;
   localparam logic [7:0] RFI_IDX_MASK   = 8'h0D;
   localparam logic [7:0] RFI_IDX_COLL   = 8'h10;
   localparam logic [7:0] RFI_IDX_FIFO   = 8'h14;
   localparam logic [7:0] RFI_ADR_PROTO  = 8'h04;
   localparam logic [7:0] RFI_ADR_WAIT   = 8'h1C;
   localparam logic [7:0] RFI_ADR_STATUS = 8'h30;
   localparam logic [7:0] RFI_ADR_MASK   = 8'h34;
   localparam logic [7:0] RFI_ADR_COLL   = 8'h40;
   localparam logic [7:0] RFI_ADR_FIFO   = 8'h50;
   // status bit positions
   localparam int RFI_B_TX   = 7;
   localparam int RFI_B_SRX  = 6;
   localparam int RFI_B_FIFO = 5;
   localparam int RFI_B_CRC  = 4;
   localparam int RFI_B_PAR  = 3;
   localparam int RFI_B_FRM  = 2;
   localparam int RFI_B_COL  = 1;
   localparam int RFI_B_NR   = 0;
   // protocol control fields
   localparam int         RFI_PROTO_CRC_OFF = 7;
   localparam int         RFI_PROTO_MODE_LO = 0;
   localparam logic [1:0] RFI_MODE_15693    = 2'h0;
   localparam logic [1:0] RFI_MODE_14443A   = 2'h1;
   localparam int         RFI_COLL_SEL7     = 0;
   localparam logic [2:0] RFI_COLL_THR6     = 3'h6;
   localparam logic [2:0] RFI_COLL_THR7     = 3'h7;
   // reset values
   localparam logic [7:0] RFI_RST_STATUS = 8'h00;
   localparam logic [7:0] RFI_RST_PROTO  = 8'h00;
   localparam logic [7:0] RFI_RST_WAIT   = 8'h10;
   localparam logic [7:0] RFI_RST_MASK   = 8'hFE;
   localparam logic [7:0] RFI_RST_COLL   = 8'h00;
   localparam logic [7:0] RFI_RST_FIFO   = 8'hC2;

   typedef enum logic [1:0] {
      RFI_IDLE = 2'b00,
      RFI_TX   = 2'b01,
      RFI_WAIT = 2'b11,
      RFI_RX   = 2'b10
   } rfi_phase_t;

   typedef struct packed {
      logic tx_active;
      logic rx_active;
      logic rx_sof;
      logic crc_err;
      logic parity_err;
      logic framing_err;
      logic coll_hit;
      logic bit_tick;
      logic read_done;
   } rfi_evt_t;
endpackage

/* File: hw/rfi_coll_count.sv */
// rfi_coll_count: counts collision hits inside one bit period and
// flags when the count passes 6 or 7. inputs are same-clock pulses.
`timescale 1ns/100ps
`default_nettype none
module rfi_coll_count
   import rfi_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // events
   input  wire logic coll_hit,
   input  wire logic bit_tick,
   input  wire logic sel7,
   // result
   output logic      over_q
);
   logic [2:0] cnt_q;
   logic [2:0] thr;

   assign thr = sel7 ? RFI_COLL_THR7 : RFI_COLL_THR6;

   // count restarts each bit period, saturates
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         cnt_q <= 3'h0;
      else if (bit_tick)
         cnt_q <= 3'h0;
      else if (coll_hit && cnt_q != 3'h7)
         cnt_q <= cnt_q + 3'h1;
   end

   // one pulse when the count first goes past 6; at threshold 7 every hit after the seventh pulses
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         over_q <= 1'b0;
      else
         over_q <= coll_hit && !bit_tick && cnt_q == thr;  // see [R10]
   end

   property p_coll_over;
      @(posedge clock) disable iff (!reset_n)
      over_q |-> $past(cnt_q) == $past(thr) && $past(coll_hit);
   endproperty
   a_coll_over: assert property (p_coll_over)  // see [R10]
      else $error("collision flag without threshold crossing");
endmodule
`default_nettype wire

/* File: hw/rfi_irq_status.sv */
// rfi_irq_status: event flags, phase tracking and interrupt line of the
// reader, with an APB register slave. event inputs share the clock;
// chip_enable is a pin and is synchronised.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R01] status clears at reset, while enable is low, on protocol writes
// [R02] end of a read phase clears status and drops the line
// [R03] host read of status clears flags and drops the line
// [R04] tx flag sets at tx start, line raised only after tx ends
// [R05] rx flag sets on start of frame, line raised after rx ends
// [R06] fifo flag on crossing the programmed high or low level
// [R07] crc flag only while receive crc check is enabled
// [R08] parity flag in 14443 A receive only; the code also sets it in 14443 A while idle or in response wait
// [R09] framing or end-of-frame error flag
// [R10] collision flag when hits in one bit pass 6 or 7
// [R11] no-response flag after wait time, 15693 only
// [R12] during transmit only fifo and tx flags change
// [R13] during receive only rx flag changes, line held off
// [R14] flags accumulate, line stays until cleared; the code also drops the line at each tx or rx start
module rfi_irq_status
   import rfi_pkg::*;
#(
   parameter int NORESP_TICK_CYC = RFI_TICK_CYC
)
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // apb slave
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // chip enable pin
   input  wire logic       chip_enable,
   // link events
   input  wire rfi_evt_t   evt,
   input  wire logic [6:0] fifo_level,
   // interrupt line
   output logic            irq_q
);
   logic        en_meta_q, en_sync_q;
   logic [7:0]  status_q, status_d, proto_q, wait_q, mask_q;
   logic [7:0]  coll_cfg_q, fifo_cfg_q, rd_q, rd_d, deferred_q;
   logic [7:0]  set_now, keep, unit_q;
   logic [15:0] tick_q, tick_last;
   logic        arm_q, arm_d, above_q, below_q, coll_over;
   rfi_phase_t  phase_q;
   logic        acc, hit, wr_proto, rd_status, wr_status, clr_all, clr_any;
   logic        busy, tx_start, tx_end, rx_start, rx_end, timeout;
   logic        fifo_cross, crc_ev, par_ev, col_ev;
   logic [1:0]  mode;
   logic [6:0]  hi_thr, lo_thr;

   default clocking cb_main @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // enable pin synchroniser
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
      end
      else
      begin
         en_meta_q <= chip_enable;
         en_sync_q <= en_meta_q;
      end
   end

   // apb decode, zero wait states
   assign acc       = psel && penable;
   assign hit       = paddr == RFI_ADR_PROTO || paddr == RFI_ADR_WAIT ||
                      paddr == RFI_ADR_STATUS || paddr == RFI_ADR_MASK ||
                      paddr == RFI_ADR_COLL || paddr == RFI_ADR_FIFO;
   assign pready    = 1'b1;
   assign pslverr   = acc && !hit;
   assign prdata    = {24'h00_0000, rd_q};
   assign wr_proto  = acc && pwrite && paddr == RFI_ADR_PROTO;
   assign wr_status = acc && pwrite && paddr == RFI_ADR_STATUS;
   assign rd_status = acc && !pwrite && paddr == RFI_ADR_STATUS;

   always_comb
   begin
      rd_d = 8'h00;
      unique case (paddr)
         RFI_ADR_PROTO:  rd_d = proto_q;
         RFI_ADR_WAIT:   rd_d = wait_q;
         RFI_ADR_STATUS: rd_d = status_q;
         RFI_ADR_MASK:   rd_d = mask_q;
         RFI_ADR_COLL:   rd_d = coll_cfg_q;
         RFI_ADR_FIFO:   rd_d = fifo_cfg_q;
         default:        rd_d = 8'h00;
      endcase
   end

   // read data captured in the setup cycle
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         rd_q <= 8'h00;
      else if (psel && !penable && !pwrite)
         rd_q <= rd_d;
   end

   // control registers
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         proto_q    <= RFI_RST_PROTO;
         wait_q     <= RFI_RST_WAIT;
         mask_q     <= RFI_RST_MASK;
         coll_cfg_q <= RFI_RST_COLL;
         fifo_cfg_q <= RFI_RST_FIFO;
      end
      else if (acc && pwrite)
      begin
         if (paddr == RFI_ADR_PROTO)
            proto_q <= pwdata[7:0];
         if (paddr == RFI_ADR_WAIT)
            wait_q <= pwdata[7:0];
         if (paddr == RFI_ADR_MASK)
            mask_q <= pwdata[7:0];
         if (paddr == RFI_ADR_COLL)
            coll_cfg_q <= pwdata[7:0];
         if (paddr == RFI_ADR_FIFO)
            fifo_cfg_q <= pwdata[7:0];
      end
   end

   assign mode = proto_q[RFI_PROTO_MODE_LO +: 2];

   // phase tracking: idle, transmit, response wait, receive
   assign busy     = phase_q == RFI_TX || phase_q == RFI_RX;
   assign tx_start = !busy && evt.tx_active;
   assign tx_end   = phase_q == RFI_TX && !evt.tx_active;
   assign rx_start = !busy && !evt.tx_active && evt.rx_sof;
   assign rx_end   = phase_q == RFI_RX && !evt.rx_active;

   always_ff @(posedge clock)
   begin
      if (!reset_n || !en_sync_q)
         phase_q <= RFI_IDLE;
      else
      begin
         unique case (phase_q)
            RFI_IDLE:
               if (tx_start)
                  phase_q <= RFI_TX;
               else if (rx_start)
                  phase_q <= RFI_RX;
            RFI_TX:
               if (tx_end)
                  phase_q <= RFI_WAIT;
            RFI_WAIT:
               if (tx_start)
                  phase_q <= RFI_TX;
               else if (rx_start)
                  phase_q <= RFI_RX;
               else if (timeout)
                  phase_q <= RFI_IDLE;
            RFI_RX:
               if (rx_end)
                  phase_q <= RFI_IDLE;
         endcase
      end
   end

   // no-response timer, counted in ticks while waiting
   assign tick_last = 16'(NORESP_TICK_CYC - 1);
   assign timeout   = phase_q == RFI_WAIT && unit_q == wait_q;

   always_ff @(posedge clock)
   begin
      if (!reset_n || phase_q != RFI_WAIT)
      begin
         tick_q <= 16'h0000;
         unit_q <= 8'h00;
      end
      else if (tick_q == tick_last)
      begin
         tick_q <= 16'h0000;
         unit_q <= unit_q + 8'h01;
      end
      else
         tick_q <= tick_q + 16'h0001;
   end

   // fifo level crossings
   assign hi_thr     = {fifo_cfg_q[7:4], 3'b000};
   assign lo_thr     = {fifo_cfg_q[3:0], 3'b000};
   assign fifo_cross = (fifo_level >= hi_thr && !above_q) ||
                       (fifo_level <= lo_thr && !below_q);  // see [R06]

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         above_q <= 1'b0;
         below_q <= 1'b1;
      end
      else
      begin
         above_q <= fifo_level >= hi_thr;
         below_q <= fifo_level <= lo_thr;
      end
   end

   rfi_coll_count u_coll (
      .clock    (clock),
      .reset_n  (reset_n),
      .coll_hit (evt.coll_hit),
      .bit_tick (evt.bit_tick),
      .sel7     (coll_cfg_q[RFI_COLL_SEL7]),
      .over_q   (coll_over)
   );

   // decoder events, qualified by protocol
   assign crc_ev = evt.crc_err && !proto_q[RFI_PROTO_CRC_OFF];  // see [R07]
   assign par_ev = evt.parity_err && mode == RFI_MODE_14443A;   // see [R08]
   assign col_ev = coll_over &&
                   (mode == RFI_MODE_14443A || mode == RFI_MODE_15693);  // see [R10]

   // errors seen during receive wait for the end of the phase
   always_ff @(posedge clock)
   begin
      if (!reset_n || !en_sync_q || rx_end || phase_q != RFI_RX)
         deferred_q <= 8'h00;
      else
         deferred_q <= deferred_q |
                       {3'b000, crc_ev, par_ev, evt.framing_err, col_ev, 1'b0};  // see [R13]
   end

   // flag sets; decoder disabled while transmitting
   always_comb
   begin
      set_now = 8'h00;
      set_now[RFI_B_TX]  = tx_start;                            // see [R04]
      set_now[RFI_B_SRX] = rx_start;                            // see [R05]
      set_now[RFI_B_FIFO] = fifo_cross && phase_q != RFI_RX;    // see [R12]
      if (!busy && !evt.tx_active)
      begin
         set_now[RFI_B_CRC] = crc_ev;
         set_now[RFI_B_PAR] = par_ev;
         set_now[RFI_B_FRM] = evt.framing_err;                  // see [R09]
         set_now[RFI_B_COL] = col_ev;
      end
      if (rx_end)
         set_now = set_now | deferred_q;
      set_now[RFI_B_NR] = timeout && mode == RFI_MODE_15693;    // see [R11]
   end

   // clears: whole register, read-back bits, or written ones
   assign clr_all = !en_sync_q || wr_proto || evt.read_done;  // see [R01] [R02]
   assign clr_any = clr_all || rd_status || wr_status;

   always_comb
   begin
      keep = 8'hFF;
      if (clr_all)
         keep = 8'h00;
      else if (rd_status)
         keep = ~rd_q;                                          // see [R03]
      else if (wr_status)
         keep = ~pwdata[7:0];
      status_d = (status_q & keep) | set_now;                   // see [R14]
      if (!en_sync_q)
         status_d = RFI_RST_STATUS;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         status_q <= RFI_RST_STATUS;                            // see [R01]
      else
         status_q <= status_d;
   end

   // line armed at the end of a phase or by an idle-time event
   always_comb
   begin
      arm_d = arm_q;
      if (clr_any || tx_start || rx_start)
         arm_d = 1'b0;                                          // see [R13]
      if (tx_end || rx_end || (!busy && !tx_start && !rx_start && |set_now[5:0]))
         arm_d = 1'b1;                                          // see [R04] [R05]
      if (!en_sync_q)
         arm_d = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         arm_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         arm_q <= arm_d;
         irq_q <= arm_d && |(status_d & mask_q);               // see [R14]
      end
   end

   property p_proto_clear;
      wr_proto && set_now == 8'h00 |=> status_q == 8'h00;
   endproperty
   a_proto_clear: assert property (p_proto_clear)  // see [R01]
      else $error("protocol write did not clear status");
   property p_en_low;
      !en_sync_q |=> status_q == 8'h00 && !irq_q;
   endproperty
   a_en_low: assert property (p_en_low)  // see [R01]
      else $error("status or line active while disabled");
   property p_phase_clear;
      evt.read_done && set_now == 8'h00 |=> status_q == 8'h00 && !irq_q;
   endproperty
   a_phase_clear: assert property (p_phase_clear)  // see [R02]
      else $error("end of read phase left flags or line");
   property p_read_clear;
      rd_status && !clr_all |=> (status_q & $past(rd_q) & ~$past(set_now)) == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear)  // see [R03]
      else $error("status read did not clear reported flags");
   // a pending masked tx flag raises the line at the end of transmit
   property p_tx_end_irq;
      tx_end && !clr_any && en_sync_q && mask_q[RFI_B_TX] && status_q[RFI_B_TX] |=> irq_q;
   endproperty
   a_tx_end_irq: assert property (p_tx_end_irq)  // see [R04]
      else $error("line not raised at end of transmit");
   property p_rx_hold;
      phase_q == RFI_RX && evt.rx_active |=> !irq_q;
   endproperty
   a_rx_hold: assert property (p_rx_hold)  // see [R05]
      else $error("line raised while receiving");
   property p_tx_only;
      phase_q == RFI_TX && evt.tx_active && !clr_any |=>
         status_q[6] == $past(status_q[6]) && status_q[4:0] == $past(status_q[4:0]);
   endproperty
   a_tx_only: assert property (p_tx_only)  // see [R12]
      else $error("flag other than fifo or tx changed in transmit");
   property p_rx_only;
      phase_q == RFI_RX && evt.rx_active && !clr_any |=>
         status_q[7] == $past(status_q[7]) && status_q[5:0] == $past(status_q[5:0]);
   endproperty
   a_rx_only: assert property (p_rx_only)  // see [R13]
      else $error("flag other than rx changed in receive");
   property p_crc_off;
      proto_q[RFI_PROTO_CRC_OFF] && !rx_end |-> !set_now[RFI_B_CRC];
   endproperty
   a_crc_off: assert property (p_crc_off)  // see [R07]
      else $error("crc flag set with crc check off");
   property p_noresp;
      set_now[RFI_B_NR] |-> phase_q == RFI_WAIT && mode == RFI_MODE_15693 &&
         unit_q == wait_q;
   endproperty
   a_noresp: assert property (p_noresp)  // see [R11]
      else $error("no-response flag outside 15693 wait timeout");
   property p_accumulate;
      !clr_any |=> (status_q & $past(status_q)) == $past(status_q);
   endproperty
   a_accumulate: assert property (p_accumulate)  // see [R14]
      else $error("flag lost without a clear");
endmodule
`default_nettype wire

/* File: testbench/rfi_host_model.sv */
// rfi_host_model: host side apb master that reads and writes the
// irq status block. assumes each call starts right after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module rfi_host_model
(
   // clock
   input  wire logic        clock,
   // apb master
   output var logic         psel,
   output var logic         penable,
   output var logic         pwrite,
   output var logic [7:0]   paddr,
   output var logic [31:0]  pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // idle cycles give a prompt or a slow host
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input int idle, output logic [31:0] q, output logic e);
      repeat (idle) @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      // status read doubles as the acknowledge
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// tb: self-checking bench for the irq status block.
// assumes the package constants and a host model driving apb.
`timescale 1ns/100ps
`default_nettype none
module tb
   import rfi_pkg::*;
;
   localparam int         TICKS  = 4;
   localparam logic [8:0] P_SOF  = 9'h040;
   localparam logic [8:0] P_CRC  = 9'h020;
   localparam logic [8:0] P_PAR  = 9'h010;
   localparam logic [8:0] P_FRM  = 9'h008;
   localparam logic [8:0] P_COL  = 9'h004;
   localparam logic [8:0] P_TICK = 9'h002;
   localparam logic [8:0] P_RD   = 9'h001;
   logic        clock, reset_n, chip_enable, tx_l, rx_l, e;
   logic        psel, penable, pwrite, pready, pslverr, irq_q;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, seed;
   logic [6:0]  fifo_level;
   logic [8:0]  pl;
   rfi_evt_t    evt;
   int          n_errors, cmp_count, cyc, n, thr, i;
   int          lv[3] = '{100, 50, 10};
   logic [7:0]  fx[3] = '{8'h20, 8'h00, 8'h20};

   assign evt = rfi_evt_t'({tx_l, rx_l, 7'h00} | pl);

   rfi_irq_status #(.NORESP_TICK_CYC(TICKS)) DUT (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
      .evt(evt), .fifo_level(fifo_level), .irq_q(irq_q));
   rfi_host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0000_0000, int'(xs() % 3), q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, int'(xs() % 3), q, e);
   endtask

   task automatic rd_st(input logic [7:0] exp);
      rd(RFI_ADR_STATUS);
      chk(q, {24'h00_0000, exp}, "status");
   endtask

   task automatic pulse(input logic [8:0] m);
      pl <= m;
      @(posedge clock);
      pl <= 9'h000;
      @(posedge clock);
   endtask

   task automatic irq_now(input logic lvl);
      @(negedge clock);
      chk({31'h0, irq_q}, {31'h0, lvl}, "irq");
      @(posedge clock);
   endtask

   // line must reach the level within a few cycles
   task automatic wait_irq(input logic lvl);
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clock);
         if (irq_q === lvl)
            break;
      end
      chk({31'h0, irq_q}, {31'h0, lvl}, "irq wait");
      @(posedge clock);
   endtask

   task automatic tx_burst();
      tx_l <= 1'b1;
      repeat (3) @(posedge clock);
      tx_l <= 1'b0;
      repeat (20) @(posedge clock);
   endtask

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("MISMATCH at %0t: run did not finish", $time);
         conclude();
      end
   end

   initial
   begin
      reset_n = 1'b0;
      chip_enable = 1'b1;
      tx_l = 1'b0;
      rx_l = 1'b0;
      pl = 9'h000;
      fifo_level = 7'h00;
      seed = 32'h0001_8146;
      n_errors = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd_st(8'h00);
      rd(8'h3C);
      chk({31'h0, e}, 32'h0000_0001, "slverr");
      chk(q, 32'h0000_0000, "unmapped");
      // transmit: decoder errors dropped, line held until the end
      wr(RFI_ADR_PROTO, 32'h0000_0001);
      tx_l <= 1'b1;
      pulse(P_CRC | P_PAR);
      irq_now(1'b0);
      tx_l <= 1'b0;
      wait_irq(1'b1);
      rd_st(8'h80);
      irq_now(1'b0);
      // receive with errors, committed at the end of the frame
      rx_l <= 1'b1;
      pulse(P_SOF);
      pulse(P_CRC);
      pulse(P_PAR);
      pulse(P_FRM);
      irq_now(1'b0);
      rx_l <= 1'b0;
      wait_irq(1'b1);
      rd_st(8'h5C);
      // crc check off and 15693 mode leave only framing
      wr(RFI_ADR_PROTO, 32'h0000_0080);
      rx_l <= 1'b1;
      pulse(P_SOF);
      pulse(P_CRC | P_PAR | P_FRM);
      rx_l <= 1'b0;
      wait_irq(1'b1);
      rd_st(8'h44);
      // no response after the wait time
      wr(RFI_ADR_MASK, 32'h0000_00FF);
      wr(RFI_ADR_WAIT, 32'h0000_0001);
      wr(RFI_ADR_PROTO, 32'h0000_0000);
      tx_burst();
      irq_now(1'b1);
      rd_st(8'h81);
      // end of phase clears flags and line
      tx_burst();
      pulse(P_RD);
      irq_now(1'b0);
      rd_st(8'h00);
      // enable pin low, then a protocol write, each clear
      tx_burst();
      chip_enable <= 1'b0;
      repeat (4) @(posedge clock);
      chip_enable <= 1'b1;
      repeat (4) @(posedge clock);
      irq_now(1'b0);
      rd_st(8'h00);
      tx_burst();
      wr(RFI_ADR_PROTO, 32'h0000_0001);
      rd_st(8'h00);
      // collision hits in one bit window against both thresholds
      for (i = 0; i < 6; i++)
      begin
         n = 5 + int'(xs() % 4);
         thr = (i % 2 == 1) ? 7 : 6;
         wr(RFI_ADR_COLL, 32'(thr - 6));
         pulse(P_TICK);
         repeat (n) pulse(P_COL);
         repeat (4) @(posedge clock);
         rd_st((n > thr) ? 8'h02 : 8'h00);
      end
      // fifo level crossing the high then the low threshold
      for (i = 0; i < 3; i++)
      begin
         fifo_level <= 7'(lv[i]);
         repeat (4) @(posedge clock);
         rd_st(fx[i]);
      end
      conclude();
   end
endmodule
`default_nettype wire
